// >>> hw/interrupt_priority_vectoring.sv
// Function
// RL1 - 22 hardware sources plus software trap
// RL2 - local enable gates each on-chip request
// RL3 - nmi pin ignored in reset, self-masking
// RL4 - normal modes fetch vectors ffc0 to ffff
// RL5 - boot and test modes use bfc0 to bfff
// RL6 - each maskable source fixed vector and priority
// RL7 - clock fail fffc, watchdog fffa, reset fffe
// RL8 - software trap blocks others, sets i
// RL9 - software trap never pre-empts running sequence
// RL10 - undefined opcode raises non-maskable trap
// RL11 - illegal trap blocks others until handler
// RL12 - periodic rate select, flag, request enable
// RL13 - full periodic period before first flag
// RL14 - reset sets x and i
// RL15 - x clearable by transfer, never set again; code sets x again on class-x entry and on clock or watchdog failure
// RL16 - class-i entry sets i after stacking
// RL17 - class-x entry sets x and i
// RL18 - return restores prior x and i
// RL19 - fixed priority among non-i sources
// RL20 - promotion writable only while i set
// RL21 - promoted source keeps masks and vector
// RL22 - x and i block whole class
// RL23 - promotion resets to 00110, reserved same
// RL24 - stack registers before fetching the vector
module interrupt_priority_vectoring
  import intvec_pkg::*;
#(
  parameter int unsigned PERIODIC_BASE = 8192
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  special_mode,
  input  wire logic                  mode_a,
  input  wire logic                  ext_request_pin_n,
  input  wire logic                  nonmaskable_request_pin_n,
  input  wire logic [NUM_PERIPH-1:0] periph_flag,
  input  wire logic [NUM_PERIPH-1:0] periph_enable,
  input  wire logic [2:0]            periodic_rate_select,
  input  wire logic                  periodic_request_enable,
  input  wire logic                  periodic_flag_clear,
  input  wire logic                  software_trap_instruction,
  input  wire logic                  illegal_opcode,
  input  wire logic                  watchdog_monitor_fail,
  input  wire logic                  clock_fail,
  input  wire logic                  instr_boundary,
  input  wire logic                  stack_done,
  input  wire logic                  vector_ack,
  input  wire logic                  first_instr_done,
  input  wire logic                  ccr_transfer,
  input  wire logic                  ccr_wr_x,
  input  wire logic                  ccr_wr_i,
  input  wire logic                  return_from_interrupt_instruction,
  input  wire logic                  ret_x,
  input  wire logic                  ret_i,
  input  wire logic                  promote_write,
  input  wire logic [4:0]            promote_wdata,
  output logic                       x_mask,
  output logic                       i_mask,
  output logic [4:0]                 promote_select_field,
  output logic                       periodic_flag,
  output logic                       stack_req,
  output logic                       vector_valid,
  output logic [15:0]                vector_addr,
  output logic                       in_sequence
);

  typedef struct packed {
    seq_state_e           state;
    logic                 x;
    logic                 i;
    logic [4:0]           promote;
    logic [PER_CNT_W-1:0] per_cnt;
    logic                 per_flag;
    logic                 swi_pend;
    logic                 ill_pend;
    logic                 take_x;
    logic [7:0]           vec_lo;
    logic                 stack_req;
    logic                 vec_valid;
    logic                 smod;
    logic                 mda;
    logic [2:0]           irq_sync;
    logic [2:0]           nmi_sync;
    logic                 irq_lvl;
    logic                 nmi_lvl;
    logic [7:0]           vec_hi;
    logic                 busy;
  } ctl_s;

  ctl_s st_r;
  ctl_s st_nxt;

  // reserved codes fall back to the external pin slot
  function automatic logic [4:0] promote_index(input logic [4:0] code);
    logic [4:0] idx;
    idx = 5'd0;
    for (int k = 0; k < NUM_ICLASS; k++) begin
      if (ICLASS_SEL[k] == code) begin
        idx = 5'(k);
      end
    end
    return idx;
  endfunction

  // periodic period in cycles, minus one
  function automatic logic [PER_CNT_W-1:0] period_last(input logic [2:0] rate);
    logic [2:0] r;
    r = (rate > 3'(PERIODIC_RATES - 1)) ? 3'(PERIODIC_RATES - 1) : rate;
    return PER_CNT_W'((PERIODIC_BASE << r) - 1);
  endfunction

  logic [NUM_ICLASS-1:0] iclass_req;  // twenty class-i sources [RL1]
  logic [4:0]            promo_idx;
  logic                  i_found;
  logic [7:0]            i_vec;

  // gated class-I requests and resolution
  always_comb begin
    iclass_req = {periph_flag & periph_enable,                    // [RL2]
                  st_r.per_flag & periodic_request_enable,        // [RL12]
                  st_r.irq_lvl};
    promo_idx = promote_index(st_r.promote);                       // [RL23]
    i_found   = 1'b0;
    i_vec     = ICLASS_VEC[0];
    for (int k = NUM_ICLASS - 1; k >= 0; k--) begin
      if (iclass_req[k]) begin
        i_found = 1'b1;
        i_vec   = ICLASS_VEC[k];                                   // [RL6]
      end
    end
    if (iclass_req[promo_idx]) begin
      i_vec = ICLASS_VEC[promo_idx];                               // [RL21]
    end
  end

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    // pin synchronisers: level moves when stages two and three agree
    st_nxt.irq_sync = {st_r.irq_sync[1:0], ~ext_request_pin_n};
    st_nxt.nmi_sync = {st_r.nmi_sync[1:0], ~nonmaskable_request_pin_n};
    if (st_r.irq_sync[1] == st_r.irq_sync[2]) begin
      st_nxt.irq_lvl = st_r.irq_sync[2];
    end
    if (st_r.nmi_sync[1] == st_r.nmi_sync[2]) begin
      st_nxt.nmi_lvl = st_r.nmi_sync[2];
    end
    // periodic timer: flag only after a whole period, set beats clear
    if (periodic_flag_clear) begin
      st_nxt.per_flag = 1'b0;
    end
    if (st_r.per_cnt >= period_last(periodic_rate_select)) begin
      st_nxt.per_cnt  = PER_CNT_RESET;
      st_nxt.per_flag = 1'b1;                                      // [RL13]
    end else begin
      st_nxt.per_cnt = st_r.per_cnt + 1'b1;
    end
    // traps are held until the sequencer is idle
    if (software_trap_instruction) begin
      st_nxt.swi_pend = 1'b1;                                      // [RL9]
    end
    if (illegal_opcode) begin
      st_nxt.ill_pend = 1'b1;                                      // [RL10]
    end
    // promotion field writes
    if (promote_write && st_r.i) begin
      st_nxt.promote = promote_wdata;                              // [RL20]
    end
    // software transfer into the mask bits
    if (ccr_transfer) begin
      st_nxt.x = st_r.x & ccr_wr_x;                                // [RL15]
      st_nxt.i = ccr_wr_i;
    end
    if (return_from_interrupt_instruction) begin
      st_nxt.x = st_r.x & ret_x;                                   // [RL18]
      st_nxt.i = ret_i;
    end
    unique case (st_r.state)
      st_idle: begin
        // trap order: illegal, software trap, nmi pin, class I
        if (st_r.ill_pend) begin
          st_nxt.ill_pend = illegal_opcode;
          st_nxt.vec_lo   = VEC_ILLEGAL;                           // [RL19]
          st_nxt.take_x   = 1'b0;
          st_nxt.state    = st_stack;
        end else if (st_r.swi_pend) begin
          st_nxt.swi_pend = software_trap_instruction;
          st_nxt.vec_lo   = VEC_SWTRAP;                            // [RL8]
          st_nxt.take_x   = 1'b0;
          st_nxt.state    = st_stack;
        end else if (instr_boundary && st_r.nmi_lvl && !st_r.x) begin
          st_nxt.vec_lo = VEC_NMI_PIN;                             // [RL3]
          st_nxt.take_x = 1'b1;
          st_nxt.state  = st_stack;
        end else if (instr_boundary && i_found && !st_r.i) begin
          st_nxt.vec_lo = i_vec;                                   // [RL22]
          st_nxt.take_x = 1'b0;
          st_nxt.state  = st_stack;
        end
        st_nxt.stack_req = (st_nxt.state == st_stack);
      end
      st_stack: begin
        if (stack_done) begin
          st_nxt.stack_req = 1'b0;
          st_nxt.i         = 1'b1;                                 // [RL16]
          st_nxt.x         = st_r.x | st_r.take_x;                 // [RL17]
          st_nxt.vec_valid = 1'b1;                                 // [RL24]
          st_nxt.state     = st_vector;
        end
      end
      st_vector: begin
        if (vector_ack) begin
          st_nxt.vec_valid = 1'b0;
          st_nxt.state     = st_first;
        end
      end
      st_first: begin
        if (first_instr_done) begin
          st_nxt.state = st_idle;                                  // [RL11]
        end
      end
    endcase
    // reset-class failures take over at once, with no stacking
    if (clock_fail || watchdog_monitor_fail) begin
      st_nxt.vec_lo    = clock_fail ? VEC_CLOCK_FAIL : VEC_WATCHDOG; // [RL7]
      st_nxt.x         = 1'b1;
      st_nxt.i         = 1'b1;
      st_nxt.swi_pend  = 1'b0;
      st_nxt.ill_pend  = 1'b0;
      st_nxt.stack_req = 1'b0;
      st_nxt.vec_valid = 1'b1;
      st_nxt.state     = st_vector;
    end
    // sequence flag kept in a flop so the output needs no decode
    st_nxt.busy = (st_nxt.state != st_idle);
  end

  // state register; reset leaves a reset vector request pending
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r           <= '0;
      st_r.state     <= st_vector;
      st_r.x         <= 1'b1;                                      // [RL14]
      st_r.i         <= 1'b1;
      st_r.promote   <= PROMOTE_RESET;
      st_r.per_cnt   <= PER_CNT_RESET;
      st_r.vec_lo    <= VEC_RESET;
      st_r.vec_valid <= 1'b1;
      st_r.smod      <= special_mode;
      st_r.mda       <= mode_a;
      st_r.busy      <= 1'b1;
      st_r.vec_hi    <= special_mode ? VEC_PAGE_SPECIAL : VEC_PAGE_NORMAL; // [RL4] [RL5]
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign x_mask               = st_r.x;
  assign i_mask               = st_r.i;
  assign promote_select_field = st_r.promote;
  assign periodic_flag        = st_r.per_flag;
  assign stack_req            = st_r.stack_req;
  assign vector_valid         = st_r.vec_valid;
  assign vector_addr          = {st_r.vec_hi, st_r.vec_lo}; // [RL4] [RL5]
  assign in_sequence          = st_r.busy;

  // checks
  chk_x_never_rises: assert property (@(posedge clk) disable iff (reset) // [RL15]
    (!st_r.x && !$past(reset) && !clock_fail && !watchdog_monitor_fail
     && st_r.state != st_stack) |=> !st_r.x || $past(st_r.take_x))
    else $error("x bit rose without x-class entry");
  chk_promote_guard: assert property (@(posedge clk) disable iff (reset) // [RL20]
    (promote_write && !st_r.i) |=> $stable(st_r.promote))
    else $error("promotion written while i clear");
  chk_i_after_stack: assert property (@(posedge clk) disable iff (reset) // [RL16]
    (st_r.state == st_stack && stack_done) |=> st_r.i && st_r.vec_valid)
    else $error("i not set after stacking");
  chk_nmi_sets_x: assert property (@(posedge clk) disable iff (reset) // [RL17]
    (st_r.state == st_stack && stack_done && st_r.take_x) |=> st_r.x)
    else $error("x not set on x-class entry");
  chk_vector_range: assert property (@(posedge clk) disable iff (reset) // [RL5]
    vector_valid |-> vector_addr[15:8] == (st_r.smod ? VEC_PAGE_SPECIAL : VEC_PAGE_NORMAL)
                     && vector_addr[7:0] > VEC_RESERVED_TOP)
    else $error("vector outside allowed range");
  chk_masked_idle: assert property (@(posedge clk) disable iff (reset) // [RL22]
    (st_r.state == st_idle && st_r.i && st_r.x && !st_r.ill_pend && !st_r.swi_pend
     && !clock_fail && !watchdog_monitor_fail) |=> st_r.state == st_idle)
    else $error("masked class taken");
  chk_hold_first: assert property (@(posedge clk) disable iff (reset) // [RL11]
    (st_r.state == st_first && !first_instr_done && !clock_fail
     && !watchdog_monitor_fail) |=> st_r.state == st_first)
    else $error("left handler hold early");
  chk_fail_vector: assert property (@(posedge clk) disable iff (reset) // [RL7]
    clock_fail |=> vector_valid && vector_addr[7:0] == VEC_CLOCK_FAIL && st_r.x)
    else $error("clock failure vector wrong");
  chk_reset_masks: assert property (@(posedge clk) // [RL14]
    $fell(reset) |-> st_r.x && st_r.i && vector_addr[7:0] == VEC_RESET)
    else $error("reset state wrong");
  cov_nmi_entry: cover property (@(posedge clk) disable iff (reset)
    st_r.state == st_stack && st_r.take_x);
  cov_swi_entry: cover property (@(posedge clk) disable iff (reset)
    vector_valid && vector_addr[7:0] == VEC_SWTRAP);
  cov_promoted: cover property (@(posedge clk) disable iff (reset)
    st_r.state == st_idle && instr_boundary && !st_r.i && iclass_req[promo_idx]
    && promo_idx != 5'd0);
endmodule

// >>> hw/intvec_pkg.sv
package intvec_pkg;
  // sequencer states
  typedef enum logic [3:0] {
    st_idle   = 4'b0001,
    st_stack  = 4'b0010,
    st_vector = 4'b0100,
    st_first  = 4'b1000
  } seq_state_e;

  localparam int unsigned NUM_ICLASS     = 20;
  localparam int unsigned NUM_PERIPH     = 18;
  localparam int unsigned PER_CNT_W      = 20;
  localparam int unsigned PERIODIC_RATES = 6;

  // vector page: normal modes at the top, special modes 64 pages lower
  localparam logic [7:0]  VEC_PAGE_NORMAL  = 8'hff;
  localparam logic [7:0]  VEC_PAGE_SPECIAL = 8'hbf;
  localparam logic [7:0]  VEC_RESET        = 8'hfe;
  localparam logic [7:0]  VEC_CLOCK_FAIL   = 8'hfc;
  localparam logic [7:0]  VEC_WATCHDOG     = 8'hfa;
  localparam logic [7:0]  VEC_ILLEGAL      = 8'hf8;
  localparam logic [7:0]  VEC_SWTRAP       = 8'hf6;
  localparam logic [7:0]  VEC_NMI_PIN      = 8'hf4;
  localparam logic [7:0]  VEC_RESERVED_TOP = 8'hcb;

  // promotion select after reset: external request pin
  localparam logic [4:0]  PROMOTE_RESET    = 5'h06;
  localparam logic [4:0]  PROMOTE_DEFAULT  = 5'h06;
  localparam logic [2:0]  RATE_RESET       = 3'h0;
  localparam logic [PER_CNT_W-1:0] PER_CNT_RESET = '0;

  // class-I sources in fixed priority order, index 0 highest
  // 0 ext pin, 1 periodic, 2..19 peripherals
  localparam logic [NUM_ICLASS-1:0][7:0] ICLASS_VEC = {
    8'hd6, 8'hd8, 8'hcc, 8'hce, 8'hda, 8'hdc, 8'hd0, 8'hde, 8'hd2, 8'hd4,
    8'he0, 8'he2, 8'he4, 8'he6, 8'he8, 8'hea, 8'hec, 8'hee, 8'hf0, 8'hf2
  };
  localparam logic [NUM_ICLASS-1:0][4:0] ICLASS_SEL = {
    5'h14, 5'h13, 5'h19, 5'h18, 5'h12, 5'h11, 5'h17, 5'h10, 5'h16, 5'h15,
    5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08, 5'h07, 5'h06
  };
endpackage

// >>> dv/core_model.sv
module core_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic slow,
  input  wire logic stack_req,
  input  wire logic vector_valid,
  input  wire logic in_sequence,
  output logic      stack_done,
  output logic      vector_ack,
  output logic      first_instr_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_r;
  logic       st_p, vec_p, fin_p;
  // which answer the core owes next
  assign st_p  = stack_req && !stack_done;
  assign vec_p = vector_valid && !stack_req && !vector_ack;
  assign fin_p = in_sequence && !vector_valid && !stack_req && !first_instr_done;
  // one pulse per request, prompt or after a few cycles
  always_ff @(posedge clk) begin
    stack_done       <= 1'b0;
    vector_ack       <= 1'b0;
    first_instr_done <= 1'b0;
    if (reset || !(st_p || vec_p || fin_p)) begin
      wait_r <= 3'h0;
    end else if (wait_r < (slow ? 3'h4 : 3'h0)) begin
      wait_r <= wait_r + 3'h1;
    end else begin
      wait_r           <= 3'h0;
      stack_done       <= st_p;   // registers pushed first
      vector_ack       <= vec_p;  // vector fetched after stacking
      first_instr_done <= fin_p;  // handler entered
    end
  end
endmodule

// >>> dv/test_interrupt_priority_vectoring.sv
module test_interrupt_priority_vectoring
  import intvec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PB = 4;
  logic        clk = 1'b0, reset = 1'b1, special_mode = 1'b0, slow = 1'b0;
  logic        ext_n = 1'b1, nmi_n = 1'b1, per_en = 1'b0, wx = 1'b0, wi = 1'b0;
  logic [17:0] pflag = '0, pen = 18'h30000;
  logic [2:0]  rate = 3'h0;
  logic [4:0]  pdata = 5'h00;
  logic [7:0]  pl = 8'h00;
  logic        x_mask, i_mask, periodic_flag, stack_req, vector_valid, in_sequence;
  logic        stack_done, vector_ack, first_instr_done;
  logic [4:0]  promote_select_field;
  logic [15:0] vector_addr, last_vec = '0;
  int          n_errors = 0, checked = 0, cycles = 0, k;

  always #2 clk = ~clk;

  interrupt_priority_vectoring #(.PERIODIC_BASE(PB)) u_dut (
    .clk, .reset, .special_mode, .mode_a(1'b0), .ext_request_pin_n(ext_n),
    .nonmaskable_request_pin_n(nmi_n), .periph_flag(pflag), .periph_enable(pen),
    .periodic_rate_select(rate), .periodic_request_enable(per_en),
    .periodic_flag_clear(pl[4]), .software_trap_instruction(pl[0]),
    .illegal_opcode(pl[1]), .watchdog_monitor_fail(pl[2]), .clock_fail(pl[3]),
    .instr_boundary(1'b1), .stack_done, .vector_ack, .first_instr_done,
    .ccr_transfer(pl[5]), .ccr_wr_x(wx), .ccr_wr_i(wi),
    .return_from_interrupt_instruction(pl[6]), .ret_x(wx), .ret_i(wi),
    .promote_write(pl[7]), .promote_wdata(pdata), .x_mask, .i_mask,
    .promote_select_field, .periodic_flag, .stack_req, .vector_valid,
    .vector_addr, .in_sequence
  );
  core_model u_core (
    .clk, .reset, .slow, .stack_req, .vector_valid, .in_sequence,
    .stack_done, .vector_ack, .first_instr_done
  );

  // record fetched vector, cut a hang short
  always @(posedge clk) begin
    if (vector_valid && vector_ack) last_vec <= vector_addr;
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one-cycle strobe; ccr transfer and return share the mask data
  task automatic pulse(input logic [7:0] m, input logic x = 1'b0, input logic i = 1'b0);
    @(negedge clk);
    pl = m;
    wx = x;
    wi = i;
    @(negedge clk);
    pl = 8'h00;
  endtask

  // wait for a whole sequence, then compare the fetched vector
  task automatic seq(input logic [15:0] vec);
    k = 0;
    while (in_sequence !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    while (in_sequence !== 1'b0 && k < 80) begin
      @(negedge clk);
      k++;
    end
    check(last_vec, vec);
    last_vec = '0;
  endtask

  task automatic masks(input logic x, input logic i);
    check({14'h0, x_mask, i_mask}, {14'h0, x, i});
  endtask

  task automatic quiet();
    repeat (10) @(negedge clk);
    check({15'h0, in_sequence}, 16'h0000);
  endtask

  task automatic prom(input logic [4:0] d, input logic [4:0] exp);
    pdata = d;
    pulse(8'h80, 1'b0, i_mask);
    check({11'h0, promote_select_field}, {11'h0, exp});
  endtask

  task automatic do_reset(input logic sm);
    @(negedge clk);
    reset = 1'b1;
    special_mode = sm;
    repeat (3) @(negedge clk);
    check(vector_addr, {sm ? 8'hbf : 8'hff, 8'hfe});
    check({11'h0, x_mask, i_mask, stack_req, periodic_flag, vector_valid}, 16'h0019);
    check({11'h0, promote_select_field}, 16'h0006);
    last_vec = '0;
    reset = 1'b0;
  endtask

  // cycles until the periodic flag is seen set
  task automatic flag_wait();
    k = 0;
    do begin
      @(negedge clk);
      pl = 8'h00;
      k++;
    end while (periodic_flag !== 1'b1 && k < 300);
  endtask

  initial begin
    do_reset(1'b0);
    flag_wait();
    check({15'h0, k >= PB && k <= PB + 1}, 16'h0001);
    seq(16'hfffe);
    for (int c = 0; c < 8; c++) begin
      rate = c[2:0];
      pl = 8'h10;
      flag_wait();
      pl = 8'h10;
      flag_wait();
      check(k[15:0], 16'(PB << (c > 5 ? 5 : c)));
    end
    $display("test reset and rates done");
    nmi_n = 1'b0;
    ext_n = 1'b0;
    pflag = 18'h30000;
    quiet();
    prom(5'h14, 5'h14);
    pulse(8'h20, 1'b0, 1'b1);
    seq(16'hfff4);
    masks(1'b1, 1'b1);
    nmi_n = 1'b1;
    repeat (4) @(negedge clk);  // pin level must drop before the return
    pulse(8'h40, 1'b0, 1'b1);
    masks(1'b0, 1'b1);
    pulse(8'h20, 1'b1, 1'b1);
    masks(1'b0, 1'b1);
    $display("test nonmaskable pin done");
    pulse(8'h20);
    seq(16'hffd6);
    masks(1'b0, 1'b1);
    pflag[17] = 1'b0;
    pulse(8'h40);
    seq(16'hfff2);
    ext_n = 1'b1;
    repeat (4) @(negedge clk);  // let the pin level settle
    pulse(8'h40);
    seq(16'hffd8);
    pflag = 18'h00001;
    pulse(8'h40);
    quiet();
    prom(5'h0a, 5'h14);
    pulse(8'h20, 1'b0, 1'b1);
    pdata = 5'h1a;
    pulse(8'h80, 1'b0, 1'b1);
    pflag = 18'h30000;
    pulse(8'h20);
    seq(16'hffd8);
    pflag = 18'h20000;
    pulse(8'h40);
    seq(16'hffd6);
    pflag = '0;
    rate = 3'h0;
    per_en = 1'b1;
    pulse(8'h40);
    seq(16'hfff0);
    per_en = 1'b0;
    $display("test class i done");
    pulse(8'h03);
    seq(16'hfff8);
    seq(16'hfff6);
    masks(1'b0, 1'b1);
    ext_n = 1'b0;
    slow = 1'b1;
    repeat (4) @(negedge clk);  // pin request must win before the trap
    pulse(8'h40);
    pulse(8'h01);
    seq(16'hfff2);
    ext_n = 1'b1;
    seq(16'hfff6);
    slow = 1'b0;
    pulse(8'h0c);
    seq(16'hfffc);
    pulse(8'h04);
    seq(16'hfffa);
    $display("test traps and failures done");
    do_reset(1'b1);
    seq(16'hbffe);
    pulse(8'h01);
    seq(16'hbff6);
    $display("test special mode done");
    end_sim();
  end
endmodule
